// File: icfl_biu_model.sv
`timescale 1ns/1ps
`default_nettype none
module icfl_biu_model (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        biu_req_q,
   input  wire logic [31:0] biu_addr_q,
   input  wire logic [2:0]  err_beat,
   input  wire logic        slow,
   output logic             bus_dw_valid,
   output logic [31:0]      bus_dw_even,
   output logic [31:0]      bus_dw_odd,
   output logic             bus_err
);
   logic [31:0] a;
   logic [1:0]  d;
   // Released lines show the inverse of the last beat, except after a slow burst, where the last beat is inverted twice and reappears
   task automatic idle();
      bus_dw_valid = 1'b0;
      bus_err      = 1'b0;
      bus_dw_even  = ~bus_dw_even;
      bus_dw_odd   = ~bus_dw_odd;
   endtask
   initial begin
      bus_dw_valid = 1'b0;
      bus_err      = 1'b0;
      bus_dw_even  = 32'h0000_0000;
      bus_dw_odd   = 32'h0000_0000;
      forever begin
         @(negedge clock);
         if (rst_b && biu_req_q) begin
            a = biu_addr_q;
            repeat (slow ? 4 : 1) @(negedge clock);
            for (int k = 0; k < 4; k++) begin
               d = a[4:3] + k[1:0];
               bus_dw_valid = 1'b1;
               bus_dw_even  = {a[31:5], d, 3'h0} ^ 32'hC3C3_0000;
               bus_dw_odd   = {a[31:5], d, 3'h4} ^ 32'hC3C3_0000;
               bus_err      = (k[2:0] == err_beat);
               @(negedge clock);
               if (slow) begin
                  idle();
                  repeat (3) @(negedge clock);
               end
            end
            idle();
         end
      end
   end
endmodule
`default_nettype wire

// File: icfl_cache.sv
// Summary of operation
// - 128 sets, two ways, eight words
// - Lines aligned to eight-word memory regions
// - Refill starts at missed word, streams out
// - Fill invalid way first, else pseudorandom
// - Tags hold physical addresses, no flush
// - Index both ways with address bits 11:5
// - Compare both tags with translated bits 31:12
// - Bits 4:2 pick double-word sent on hit
// - Last word of line returns one word
// - Miss address to bus unit, beats data cache
// - Bus unit runs an eight-word burst
// - Burst order critical double-word then wrap
// - Each fill word written and forwarded together
// - Fetching resumes while refill continues
// - Bus error leaves line invalid, raises exception
// - Clean refill marks line valid
// - Supervisor command flash-invalidates in two clocks
// - Single line invalidate by physical address
`timescale 1ns/1ps
`default_nettype none
module icfl_cache
   import icfl_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        fetch_req,
   input  wire logic [31:0] fetch_la,
   input  wire logic [19:0] fetch_pa_hi,
   output logic             fetch_ack_q,
   output logic             fetch_two_q,
   output logic [31:0]      fetch_word0_q,
   output logic [31:0]      fetch_word1_q,
   output logic             fetch_err_q,
   output logic             biu_req_q,
   output logic [31:0]      biu_addr_q,
   output logic             dc_defer_q,
   input  wire logic        bus_dw_valid,
   input  wire logic [31:0] bus_dw_even,
   input  wire logic [31:0] bus_dw_odd,
   input  wire logic        bus_err,
   output logic             strm_valid_q,
   output logic [31:0]      strm_pa_q,
   output logic [31:0]      strm_word0_q,
   output logic [31:0]      strm_word1_q,
   output logic             access_exc_q,
   input  wire logic        supervisor,
   input  wire logic        cmd_inv_all,
   input  wire logic        cmd_inv_line,
   input  wire logic [31:0] cmd_line_pa,
   output logic             inv_done_q
);

   // Double-words a fetch needs: one, or two when it straddles
   function automatic logic [3:0] need_dw(input logic [2:0] w);
      logic [3:0] m;
      m = 4'h0;
      m[w[2:1]] = 1'b1;
      if (w[0] && w != ICFL_LAST_WRD) begin
         m[w[2:1] + 2'h1] = 1'b1;
      end
      return m;
   endfunction

   logic [31:0]           data_mem [ICFL_WAYS][ICFL_SETS][ICFL_WORDS];
   logic [ICFL_TAG_W-1:0] tag_mem  [ICFL_WAYS][ICFL_SETS];
   logic [ICFL_SETS-1:0]  valid_q  [ICFL_WAYS];

   icfl_state_t state_q;
   logic        repl_q;
   logic [6:0]  fill_idx_q;
   logic [19:0] fill_tag_q;
   logic        fill_way_q;
   logic [1:0]  fill_dw0_q;
   logic [1:0]  beat_q;
   logic [3:0]  arrived_q;
   logic        fill_err_q;
   logic        pend_q;
   logic        pend_all_q;
   logic [6:0]  pend_idx_q;
   logic [19:0] pend_tag_q;
   logic        inv_all_q;
   logic [6:0]  inv_idx_q;
   logic [19:0] inv_tag_q;
   logic [1:0]  inv_cnt_q;

   wire [6:0]  idx      = fetch_la[ICFL_IDX_HI:ICFL_IDX_LO];
   wire [2:0]  wrd      = fetch_la[ICFL_WRD_HI:ICFL_WRD_LO];
   wire [2:0]  wrd_nxt  = wrd + 3'h1;
   wire        in_idle  = (state_q == ICFL_IDLE);
   wire        in_fill  = (state_q == ICFL_FILL);
   wire        in_inv   = (state_q == ICFL_INV);
   // Physical tags make hits independent of the process context
   wire [1:0]  tag_hit;
   assign tag_hit[0] = valid_q[0][idx]
                       && tag_mem[0][idx] == fetch_pa_hi;
   assign tag_hit[1] = valid_q[1][idx]
                       && tag_mem[1][idx] == fetch_pa_hi;
   wire        fill_match = in_fill && idx == fill_idx_q
                            && fetch_pa_hi == fill_tag_q;
   wire        fill_ready = fill_match
                            && (need_dw(wrd) & ~arrived_q) == 4'h0;
   wire        inv_go   = in_idle && pend_q;
   wire        take     = fetch_req && !fetch_ack_q && !in_inv && !inv_go;
   wire        serve    = take && ((|tag_hit) || fill_ready);
   wire        miss     = take && in_idle && !(|tag_hit);
   wire        rd_way   = fill_ready ? fill_way_q : tag_hit[1];
   wire        victim   = !valid_q[0][idx] ? 1'b0 :
                          !valid_q[1][idx] ? 1'b1 : repl_q;
   wire        beat     = in_fill && bus_dw_valid;
   wire [1:0]  beat_dw  = fill_dw0_q + beat_q;
   wire        fill_end = beat && beat_q == 2'(ICFL_BEATS - 1);
   wire        err_now  = fill_err_q || (beat && bus_err);
   wire        inv_end  = in_inv && inv_cnt_q == ICFL_INV_CLKS - 2'h1;
   wire        cmd_ok   = supervisor && (cmd_inv_all || cmd_inv_line);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ICFL_IDLE;
      end else begin
         case (state_q)
            ICFL_IDLE: begin
               if (inv_go) begin
                  state_q <= ICFL_INV;
               end else if (miss) begin
                  state_q <= ICFL_FILL;
               end
            end
            ICFL_FILL: begin
               if (fill_end) begin
                  state_q <= ICFL_IDLE;
               end
            end
            ICFL_INV: begin
               if (inv_end) begin
                  state_q <= ICFL_IDLE;
               end
            end
            default: state_q <= ICFL_IDLE;
         endcase
      end
   end

   // Array storage carries no reset; validity lives in valid_q
   always_ff @(posedge clock) begin
      if (miss) begin
         tag_mem[victim][idx] <= fetch_pa_hi;
      end
      if (beat) begin
         data_mem[fill_way_q][fill_idx_q][{beat_dw, 1'b0}] <= bus_dw_even;
         data_mem[fill_way_q][fill_idx_q][{beat_dw, 1'b1}] <= bus_dw_odd;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         valid_q[0] <= '0;
         valid_q[1] <= '0;
      end else if (miss) begin
         valid_q[victim][idx] <= 1'b0;
      end else if (fill_end) begin
         valid_q[fill_way_q][fill_idx_q] <= !err_now;
      end else if (inv_end && inv_all_q) begin
         valid_q[0] <= '0;
         valid_q[1] <= '0;
      end else if (inv_end) begin
         for (int w = 0; w < ICFL_WAYS; w++) begin
            if (tag_mem[w][inv_idx_q] == inv_tag_q) begin
               valid_q[w][inv_idx_q] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         repl_q     <= ICFL_REPL_RST;
         fill_idx_q <= '0;
         fill_tag_q <= '0;
         fill_way_q <= 1'b0;
         fill_dw0_q <= '0;
         beat_q     <= '0;
         arrived_q  <= '0;
         fill_err_q <= 1'b0;
      end else if (miss) begin
         repl_q     <= !repl_q;
         fill_idx_q <= idx;
         fill_tag_q <= fetch_pa_hi;
         fill_way_q <= victim;
         fill_dw0_q <= wrd[2:1];
         beat_q     <= '0;
         arrived_q  <= '0;
         fill_err_q <= 1'b0;
      end else if (beat) begin
         beat_q              <= beat_q + 2'h1;
         arrived_q[beat_dw]  <= 1'b1;
         fill_err_q          <= err_now;
      end
   end

   // Bus request holds until the first beat; the data cache waits
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         biu_req_q  <= 1'b0;
         dc_defer_q <= 1'b0;
         biu_addr_q <= '0;
      end else if (miss) begin
         biu_req_q  <= 1'b1;
         dc_defer_q <= 1'b1;
         biu_addr_q <= {fetch_pa_hi, fetch_la[11:2], 2'h0};
      end else if (beat) begin
         biu_req_q  <= 1'b0;
         dc_defer_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         strm_valid_q <= 1'b0;
         strm_pa_q    <= '0;
         strm_word0_q <= '0;
         strm_word1_q <= '0;
         access_exc_q <= 1'b0;
      end else begin
         strm_valid_q <= beat;
         access_exc_q <= beat && bus_err && !fill_err_q;
         if (beat) begin
            strm_pa_q    <= {fill_tag_q, fill_idx_q, beat_dw, 3'h0};
            strm_word0_q <= bus_dw_even;
            strm_word1_q <= bus_dw_odd;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fetch_ack_q   <= 1'b0;
         fetch_two_q   <= 1'b0;
         fetch_err_q   <= 1'b0;
         fetch_word0_q <= '0;
         fetch_word1_q <= '0;
      end else begin
         fetch_ack_q <= serve;
         if (serve) begin
            fetch_two_q   <= wrd != ICFL_LAST_WRD;
            fetch_err_q   <= fill_ready && fill_err_q;
            fetch_word0_q <= data_mem[rd_way][idx][wrd];
            fetch_word1_q <= data_mem[rd_way][idx][wrd_nxt];
         end
      end
   end

   // Commands that land during a fill wait here; a new line command replaces a pending line, but a pending flash is kept
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pend_q     <= 1'b0;
         pend_all_q <= 1'b0;
         pend_idx_q <= '0;
         pend_tag_q <= '0;
         inv_all_q  <= 1'b0;
         inv_idx_q  <= '0;
         inv_tag_q  <= '0;
         inv_cnt_q  <= '0;
         inv_done_q <= 1'b0;
      end else begin
         inv_done_q <= inv_end;
         inv_cnt_q  <= in_inv ? inv_cnt_q + 2'h1 : 2'h0;
         if (inv_go) begin
            inv_all_q <= pend_all_q;
            inv_idx_q <= pend_idx_q;
            inv_tag_q <= pend_tag_q;
         end
         if (cmd_ok) begin
            pend_q     <= 1'b1;
            pend_all_q <= cmd_inv_all || (pend_q && pend_all_q);
            pend_idx_q <= cmd_line_pa[ICFL_IDX_HI:ICFL_IDX_LO];
            pend_tag_q <= cmd_line_pa[31:ICFL_TAG_LO];
         end else if (inv_go) begin
            pend_q     <= 1'b0;
            pend_all_q <= 1'b0;
         end
      end
   end

   // Checks watch internal state as well, since the ports hide the choice
   chk_ack_one_pulse: assert property (@(posedge clock)
      disable iff (!rst_b) fetch_ack_q |=> !fetch_ack_q)
      else $error("fetch ack held longer than one cycle");

   chk_last_word_single: assert property (@(posedge clock)
      disable iff (!rst_b) serve && wrd == ICFL_LAST_WRD
      |=> fetch_ack_q && !fetch_two_q)
      else $error("last word fetch returned two words");

   chk_miss_bus_addr: assert property (@(posedge clock)
      disable iff (!rst_b)
      miss |=> biu_req_q && biu_addr_q[31:12] == $past(fetch_pa_hi))
      else $error("miss did not request the missing address");

   chk_dcache_deferred: assert property (@(posedge clock)
      disable iff (!rst_b) biu_req_q |-> dc_defer_q)
      else $error("data cache not deferred during fetch miss");

   chk_stream_beat: assert property (@(posedge clock)
      disable iff (!rst_b)
      beat |=> strm_valid_q && strm_word0_q == $past(bus_dw_even))
      else $error("fill beat not forwarded");

   chk_inv_two_clk: assert property (@(posedge clock)
      disable iff (!rst_b)
      $rose(in_inv) |-> !inv_done_q ##1 !inv_done_q ##1 inv_done_q)
      else $error("invalidation did not take two clocks");

   chk_fill_valid: assert property (@(posedge clock)
      disable iff (!rst_b)
      fill_end && !err_now |=> valid_q[$past(fill_way_q)][$past(fill_idx_q)])
      else $error("clean fill left line invalid");

   chk_err_invalid: assert property (@(posedge clock)
      disable iff (!rst_b)
      fill_end && err_now |=> !valid_q[$past(fill_way_q)][$past(fill_idx_q)])
      else $error("errored fill marked line valid");

   chk_err_exception: assert property (@(posedge clock)
      disable iff (!rst_b) beat && bus_err && !fill_err_q |=> access_exc_q)
      else $error("bus error raised no access exception");

   chk_fill_beats: assert property (@(posedge clock)
      disable iff (!rst_b) miss |=> in_fill && beat_q == 2'h0)
      else $error("miss did not start a burst fill");

   chk_flash_clear: assert property (@(posedge clock)
      disable iff (!rst_b)
      inv_end && inv_all_q |=> valid_q[0] == '0 && valid_q[1] == '0)
      else $error("flash invalidate left valid lines");

   chk_victim_empty: assert property (@(posedge clock)
      disable iff (!rst_b) miss && valid_q[0][idx] && !valid_q[1][idx]
      |=> fill_way_q == 1'b1)
      else $error("valid way chosen while other way was empty");

   chk_repl_toggle: assert property (@(posedge clock)
      disable iff (!rst_b) miss |=> repl_q != $past(repl_q))
      else $error("replacement bias did not toggle on miss");

   chk_fill_line_unhit: assert property (@(posedge clock)
      disable iff (!rst_b) in_fill |-> !valid_q[fill_way_q][fill_idx_q])
      else $error("line under refill reported valid");

   chk_crit_dw_first: assert property (@(posedge clock)
      disable iff (!rst_b) miss |=> fill_dw0_q ==
      $past(fetch_la[ICFL_WRD_HI:ICFL_WRD_LO+1]))
      else $error("refill did not start at the missed double-word");

   chk_line_inv_way0: assert property (@(posedge clock)
      disable iff (!rst_b) inv_end && !inv_all_q
      && tag_mem[0][inv_idx_q] == inv_tag_q
      |=> !valid_q[0][$past(inv_idx_q)])
      else $error("single line invalidate left matching line valid");
endmodule
`default_nettype wire

// File: icfl_pkg.sv
`default_nettype none
package icfl_pkg;
   localparam int ICFL_SETS   = 128;
   localparam int ICFL_WAYS   = 2;
   localparam int ICFL_WORDS  = 8;
   localparam int ICFL_TAG_W  = 20;
   localparam int ICFL_BEATS  = 4;
   localparam int ICFL_IDX_LO = 5;
   localparam int ICFL_IDX_HI = 11;
   localparam int ICFL_WRD_LO = 2;
   localparam int ICFL_WRD_HI = 4;
   localparam int ICFL_TAG_LO = 12;
   // Clocks taken by a flash or single-line invalidation
   localparam logic [1:0] ICFL_INV_CLKS = 2'h2;
   localparam logic [2:0] ICFL_LAST_WRD = 3'h7;
   localparam logic       ICFL_REPL_RST = 1'h0;
   typedef enum logic [2:0] {
      ICFL_IDLE = 3'h1,
      ICFL_FILL = 3'h2,
      ICFL_INV  = 3'h4
   } icfl_state_t;
endpackage
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import icfl_pkg::*;
   logic clock, rst_b, fetch_req, supervisor, cmd_inv_all, slow;
   logic cmd_inv_line;
   logic [31:0] fetch_la, bus_dw_even, bus_dw_odd, biu_addr_q;
   logic [19:0] fetch_pa_hi;
   logic [2:0]  err_beat;
   logic fetch_ack_q, fetch_two_q, fetch_err_q, biu_req_q, dc_defer_q;
   logic bus_dw_valid, bus_err, strm_valid_q, access_exc_q, inv_done_q;
   logic [31:0] fetch_word0_q, fetch_word1_q, strm_pa_q, strm_word0_q;
   logic [31:0] strm_word1_q, cmd_line_pa;
   logic [31:0] spa[$];
   int          err_count, n_tests, exc_n, lat;
   logic        miss_seen;
   icfl_cache dut (.clock(clock), .rst_b(rst_b), .fetch_req(fetch_req),
      .fetch_la(fetch_la), .fetch_pa_hi(fetch_pa_hi),
      .fetch_ack_q(fetch_ack_q), .fetch_two_q(fetch_two_q),
      .fetch_word0_q(fetch_word0_q), .fetch_word1_q(fetch_word1_q),
      .fetch_err_q(fetch_err_q), .biu_req_q(biu_req_q),
      .biu_addr_q(biu_addr_q), .dc_defer_q(dc_defer_q),
      .bus_dw_valid(bus_dw_valid), .bus_dw_even(bus_dw_even),
      .bus_dw_odd(bus_dw_odd), .bus_err(bus_err),
      .strm_valid_q(strm_valid_q), .strm_pa_q(strm_pa_q),
      .strm_word0_q(strm_word0_q), .strm_word1_q(strm_word1_q),
      .access_exc_q(access_exc_q), .supervisor(supervisor),
      .cmd_inv_all(cmd_inv_all), .cmd_inv_line(cmd_inv_line),
      .cmd_line_pa(cmd_line_pa), .inv_done_q(inv_done_q));
   icfl_biu_model biu (.clock(clock), .rst_b(rst_b), .biu_req_q(biu_req_q),
      .biu_addr_q(biu_addr_q), .err_beat(err_beat), .slow(slow),
      .bus_dw_valid(bus_dw_valid), .bus_dw_even(bus_dw_even),
      .bus_dw_odd(bus_dw_odd), .bus_err(bus_err));
   function automatic logic [31:0] pat(input logic [31:0] a);
      return a ^ 32'hC3C3_0000;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Ack of the request is awaited under a bound; lat counts the cycles
   task automatic fetch(input logic [31:0] pa);
      lat = 0;
      miss_seen = 1'b0;
      @(negedge clock);
      fetch_req = 1'b1;
      fetch_la = pa;
      fetch_pa_hi = pa[31:12];
      do begin
         @(negedge clock);
         lat++;
      end while (fetch_ack_q !== 1'b1 && lat < 300);
      fetch_req = 1'b0;
      chk(fetch_ack_q, 1);
   endtask
   task automatic wait_fill();
      for (int i = 0; i < 60 && spa.size() < 4; i++) @(negedge clock);
      repeat (3) @(negedge clock);
   endtask
   always @(posedge clock) begin
      if (strm_valid_q) begin
         spa.push_back(strm_pa_q);
         chk(strm_word0_q, pat(strm_pa_q));
         chk(strm_word1_q, pat(strm_pa_q + 32'h4));
      end
      if (access_exc_q) exc_n++;
      if (biu_req_q) begin
         chk(dc_defer_q, 1);
         miss_seen = 1'b1;
      end
   end
   task automatic t_miss_wrap();
      spa = {};
      fetch(32'h0001_2358);
      chk(miss_seen, 1);
      chk(biu_addr_q, 32'h0001_2358);
      chk({fetch_two_q, fetch_err_q}, 2'h2);
      chk(fetch_word0_q, pat(32'h0001_2358));
      chk(fetch_word1_q, pat(32'h0001_235C));
      wait_fill();
      chk(spa.size(), 4);
      for (int k = 0; k < 4; k++)
         chk(spa[k], 32'h0001_2340 + ((3 + k) % 4) * 8);
   endtask
   task automatic t_hits();
      fetch(32'h0001_235C);
      chk(lat, 1);
      chk(fetch_two_q, 0);
      chk(fetch_word0_q, pat(32'h0001_235C));
      fetch(32'h0001_2344);
      chk({lat[1:0], miss_seen, fetch_two_q}, 4'h5);
      chk(fetch_word1_q, pat(32'h0001_2348));
   endtask
   task automatic t_bus_err();
      spa = {};
      exc_n = 0;
      slow = 1'b1;
      err_beat = 3'h1;
      fetch(32'h0004_5600);
      fetch(32'h0004_5610);
      chk(fetch_err_q, 1);
      wait_fill();
      chk(exc_n, 1);
      err_beat = 3'h4;
      slow = 1'b0;
      spa = {};
      fetch(32'h0004_5600);
      chk(miss_seen, 1);
      wait_fill();
   endtask
   task automatic t_inv();
      int n;
      n = 0;
      @(negedge clock);
      cmd_inv_all = 1'b1;
      @(negedge clock);
      cmd_inv_all = 1'b0;
      repeat (6) @(negedge clock);
      chk(inv_done_q, 0);
      supervisor = 1'b1;
      cmd_inv_all = 1'b1;
      do begin
         @(negedge clock);
         cmd_inv_all = 1'b0;
         n++;
      end while (inv_done_q !== 1'b1 && n < 20);
      chk(n, 4);
      spa = {};
      fetch(32'h0004_5600);
      chk(miss_seen, 1);
      wait_fill();
   endtask
   // Second tag in a half-filled set, then drop only the first line
   task automatic t_inv_line();
      int n;
      n = 0;
      spa = {};
      fetch(32'h0004_6600);
      chk(miss_seen, 1);
      wait_fill();
      fetch(32'h0004_5604);
      chk({lat[1:0], miss_seen}, 3'h2);
      fetch(32'h0004_6604);
      chk({lat[1:0], miss_seen}, 3'h2);
      @(negedge clock);
      cmd_inv_line = 1'b1;
      cmd_line_pa = 32'h0004_5600;
      do begin
         @(negedge clock);
         cmd_inv_line = 1'b0;
         n++;
      end while (inv_done_q !== 1'b1 && n < 20);
      chk(n, 4);
      fetch(32'h0004_6608);
      chk({lat[1:0], miss_seen}, 3'h2);
      spa = {};
      fetch(32'h0004_5608);
      chk(miss_seen, 1);
      chk(fetch_word0_q, pat(32'h0004_5608));
      wait_fill();
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #200000;
      err_count++;
      stop_test();
   end
   initial begin
      {rst_b, fetch_req, supervisor, cmd_inv_all, cmd_inv_line, slow} = 6'h00;
      cmd_line_pa = 32'h0000_0000;
      fetch_la = 32'h0000_0000;
      fetch_pa_hi = 20'h0_0000;
      err_beat = 3'h4;
      err_count = 0;
      n_tests = 0;
      repeat (5) @(negedge clock);
      rst_b = 1'b1;
      t_miss_wrap();
      t_hits();
      t_bus_err();
      t_inv();
      t_inv_line();
      stop_test();
   end
endmodule
`default_nettype wire
